// ===== ctrim_regs.vh
// Register offsets, field positions, reset values and constants of the trim register bank
`ifndef CTRIM_REGS_VH
`define CTRIM_REGS_VH

// ****************************************************************
// Register indices (printed offsets, byte address is four times)
// ****************************************************************
`define CTRIM_IDX_FTEST3      10'h2F6
`define CTRIM_IDX_HTTRIM      10'h2F7
`define CTRIM_IDX_OSCTRIM_HI  10'h2F8
`define CTRIM_IDX_OSCTRIM_LO  10'h2F9
`define CTRIM_IDX_CLOCK_CONFIG_LOCK        10'h2FB
`define CTRIM_IDX_STATUS      10'h2FC

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRIM_HT_OE_BIT       7
`define CTRIM_HT_TRIM_MSB     3
`define CTRIM_HT_TRIM_LSB     0
`define CTRIM_TC_MSB          15
`define CTRIM_TC_LSB          12
`define CTRIM_FREQ_MSB        9
`define CTRIM_FREQ_LSB        0
`define CTRIM_COARSE_MSB      9
`define CTRIM_COARSE_LSB      6
`define CTRIM_FINE_MSB        5
`define CTRIM_FINE_LSB        0
`define CTRIM_ST_LOCK_BIT     0
`define CTRIM_ST_OSC_UP_FLAG_BIT    1
`define CTRIM_ST_CLOCK_CONFIG_LOCK_BIT     2
`define CTRIM_ST_LOADED_BIT   3

// ****************************************************************
// Values
// ****************************************************************
`define CTRIM_UNLOCK_KEY      8'h26
`define CTRIM_HT_RESET        8'h0F
`define CTRIM_OSC_RESET       16'h0000
`define CTRIM_FTEST_RESET     8'h00
`define CTRIM_TC_OFF_A        4'h0
`define CTRIM_TC_OFF_B        4'h8
`define CTRIM_HT_WMASK        8'h8F
`define CTRIM_OSC_WMASK       16'hF3FF

`endif

// ===== ctrim_apb_slave.v
// APB slave front end: decodes a read or an aligned write into a one-cycle read or write strobe
`timescale 1ns/10ps

module ctrim_apb_slave (
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg         wrStb_r,
    output reg         rdStb_r,
    output reg  [9:0]  regIdx_r,
    output reg  [7:0]  wrData_r,
    output reg         addrOk_r
);

    // ****************************************************************
    // Capture the setup phase, act once in the first access cycle
    // ****************************************************************
    wire setupPhase = psel & ~penable;

    always @(posedge mclk) begin
        if (sys_rst) begin
            wrStb_r  <= 1'b0;
            rdStb_r  <= 1'b0;
            regIdx_r <= 10'h000;
            wrData_r <= 8'h00;
            addrOk_r <= 1'b0;
        end else begin
            wrStb_r  <= setupPhase & pwrite & (paddr[1:0] == 2'b00);
            rdStb_r  <= setupPhase & ~pwrite;
            if (setupPhase) begin
                regIdx_r <= paddr[11:2];
                wrData_r <= pwdata[7:0];
                addrOk_r <= (paddr[1:0] == 2'b00);
            end
        end
    end

endmodule // ctrim_apb_slave

// ===== ctrim_bank.v
// Trim register bank of the clock unit with APB access and flash load after reset
// Functional notes
// - The factory test register is written only in special mode and read at any time.
// - The temperature trim register has the offset enable at bit 7 and the trim field at 3..0.
// - The temperature trim register is writable without protection once the flash load is done; earlier writes are ignored.
// - With offset enable 0 the temperature offset is off and the trim bits have no effect.
// - With offset enable 1 the temperature offset selected by the trim field is applied.
// - After reset release the temperature trim field is loaded from flash.
// - After reset release both oscillator trim halves are loaded from flash.
// - Oscillator trim writes are taken only while the configuration lock bit is 0.
// - An oscillator trim write while the PLL clock is selected clears lock and osc-up flags.
// - The oscillator trim holds the tempco trim at 15..12 and the frequency trim at 9..0.
// - The frequency trim splits into a coarse part 9..6 and a fine part 5..0.
// - Tempco codes 0000 and 1000 both switch tempco compensation off.
// - Writing 0x26 to the protection register clears the lock bit; any other write sets it.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "ctrim_regs.vh"

module ctrim_bank (
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        specialMode,
    input  wire        pllClockSelect,
    input  wire        pllLockSet,
    input  wire        oscUpSet,
    input  wire        flashValid,
    input  wire [3:0]  flashTempTrim,
    input  wire [15:0] flashOscTrim,
    output reg         tempOffsetEnable,
    output reg  [3:0]  tempOffsetTrim,
    output reg         tempcoCompEnable,
    output reg  [3:0]  tempcoTrim,
    output reg  [3:0]  refOscCoarseTrim,
    output reg  [5:0]  refOscFineTrim,
    output reg  [7:0]  factoryTest,
    output reg         clockConfigLock,
    output reg         pllLockFlag,
    output reg         oscUpFlag,
    output reg         trimLoaded
);

    // ****************************************************************
    // Load state machine
    // ****************************************************************
    localparam [1:0] ST_WAIT = 2'b01;
    localparam [1:0] ST_RUN  = 2'b10;

    wire        wrStb;
    wire        rdStb;
    wire [9:0]  regIdx;
    wire [7:0]  wrData;
    wire        addrOk;

    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [7:0]  htTrim_r;
    reg  [15:0] oscTrim_r;
    reg  [7:0]  ftest_r;
    reg         lock_r;
    reg         pllLock_r;
    reg         oscUp_r;
    reg  [7:0]  rdByte;
    reg         known;

    ctrim_apb_slave uApb (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .wrStb_r  (wrStb),
        .rdStb_r  (rdStb),
        .regIdx_r (regIdx),
        .wrData_r (wrData),
        .addrOk_r (addrOk)
    );

    // True for tempco codes other than those that leave the oscillator at its nominal coefficient
    function tcActive;
        input [3:0] code;
        begin
            tcActive = (code != `CTRIM_TC_OFF_A) && (code != `CTRIM_TC_OFF_B);
        end
    endfunction

    function [15:0] mergeByte;
        input [15:0] oldVal;
        input [7:0]  newByte;
        input        hiHalf;
        begin
            if (hiHalf) begin
                mergeByte = {newByte, oldVal[7:0]};
            end else begin
                mergeByte = {oldVal[15:8], newByte};
            end
        end
    endfunction

    wire running  = (state_r == ST_RUN);
    wire wrHt     = running & wrStb & (regIdx == `CTRIM_IDX_HTTRIM);
    wire wrOscHi  = running & wrStb & (regIdx == `CTRIM_IDX_OSCTRIM_HI);
    wire wrOscLo  = running & wrStb & (regIdx == `CTRIM_IDX_OSCTRIM_LO);
    wire wrOscAny = wrOscHi | wrOscLo;
    wire oscTaken = wrOscAny & ~lock_r;
    wire wrProt   = running & wrStb & (regIdx == `CTRIM_IDX_CLOCK_CONFIG_LOCK);
    wire wrTest   = running & wrStb & (regIdx == `CTRIM_IDX_FTEST3);

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_WAIT: begin
                if (flashValid) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_WAIT;
            end
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always @(posedge mclk) begin
        if (sys_rst) begin
            state_r   <= ST_WAIT;
            htTrim_r  <= `CTRIM_HT_RESET;
            oscTrim_r <= `CTRIM_OSC_RESET;
            ftest_r   <= `CTRIM_FTEST_RESET;
            lock_r    <= 1'b0;
            pllLock_r <= 1'b0;
            oscUp_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_WAIT && flashValid) begin
                htTrim_r[3:0] <= flashTempTrim;
                oscTrim_r     <= flashOscTrim & `CTRIM_OSC_WMASK;
            end
            if (wrHt) begin
                htTrim_r <= wrData & `CTRIM_HT_WMASK;
            end
            if (oscTaken) begin
                oscTrim_r <= mergeByte(oscTrim_r, wrData, wrOscHi) & `CTRIM_OSC_WMASK;
            end
            if (wrProt) begin
                lock_r <= (wrData != `CTRIM_UNLOCK_KEY);
            end
            if (wrTest && specialMode) begin
                ftest_r <= wrData;
            end
            // Set wins over the clear caused by a trim write
            if (pllLockSet) begin
                pllLock_r <= 1'b1;
            end else if (oscTaken && pllClockSelect) begin
                pllLock_r <= 1'b0;
            end
            if (oscUpSet) begin
                oscUp_r <= 1'b1;
            end else if (oscTaken && pllClockSelect) begin
                oscUp_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always @* begin
        rdByte = 8'h00;
        known  = 1'b1;
        case (regIdx)
            `CTRIM_IDX_FTEST3:     rdByte = ftest_r;
            `CTRIM_IDX_HTTRIM:     rdByte = htTrim_r;
            `CTRIM_IDX_OSCTRIM_HI: rdByte = oscTrim_r[15:8];
            `CTRIM_IDX_OSCTRIM_LO: rdByte = oscTrim_r[7:0];
            `CTRIM_IDX_CLOCK_CONFIG_LOCK:       rdByte = {7'h00, lock_r};
            `CTRIM_IDX_STATUS:     rdByte = {4'h0, running, lock_r, oscUp_r, pllLock_r};
            default:               known  = 1'b0;
        endcase
    end

    // ****************************************************************
    // APB answer and outputs
    // ****************************************************************
    always @(posedge mclk) begin
        if (sys_rst) begin
            prdata           <= 32'h00000000;
            pready           <= 1'b0;
            pslverr          <= 1'b0;
            tempOffsetEnable <= 1'b0;
            tempOffsetTrim   <= 4'h0;
            tempcoCompEnable <= 1'b0;
            tempcoTrim       <= 4'h0;
            refOscCoarseTrim <= 4'h0;
            refOscFineTrim   <= 6'h00;
            factoryTest      <= 8'h00;
            clockConfigLock  <= 1'b0;
            pllLockFlag      <= 1'b0;
            oscUpFlag        <= 1'b0;
            trimLoaded       <= 1'b0;
        end else begin
            pready    <= (wrStb | rdStb) & ~pready;
            pslverr   <= (wrStb | rdStb) & (~known | ~addrOk);
            if (rdStb) begin
                prdata <= {24'h000000, (known & addrOk) ? rdByte : 8'h00};
            end
            tempOffsetEnable <= htTrim_r[`CTRIM_HT_OE_BIT];
            tempOffsetTrim   <= htTrim_r[`CTRIM_HT_OE_BIT] ?
                                htTrim_r[`CTRIM_HT_TRIM_MSB:`CTRIM_HT_TRIM_LSB] : 4'h0;
            tempcoCompEnable <= tcActive(oscTrim_r[`CTRIM_TC_MSB:`CTRIM_TC_LSB]);
            tempcoTrim       <= oscTrim_r[`CTRIM_TC_MSB:`CTRIM_TC_LSB];
            refOscCoarseTrim <= oscTrim_r[`CTRIM_COARSE_MSB:`CTRIM_COARSE_LSB];
            refOscFineTrim   <= oscTrim_r[`CTRIM_FINE_MSB:`CTRIM_FINE_LSB];
            factoryTest      <= ftest_r;
            clockConfigLock  <= lock_r;
            pllLockFlag      <= pllLock_r;
            oscUpFlag        <= oscUp_r;
            trimLoaded       <= running;
        end
    end

endmodule // ctrim_bank

// ===== ctrim_bank_chk.sv
// Concurrent checks on the ports of the trim register bank
`timescale 1ns/10ps
`include "ctrim_regs.vh"

module ctrim_bank_chk (
    input logic        mclk,
    input logic        sys_rst,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic        pready,
    input logic        specialMode,
    input logic        pllClockSelect,
    input logic        pllLockSet,
    input logic        oscUpSet,
    input logic        tempOffsetEnable,
    input logic [3:0]  tempOffsetTrim,
    input logic        tempcoCompEnable,
    input logic [3:0]  tempcoTrim,
    input logic [3:0]  refOscCoarseTrim,
    input logic [5:0]  refOscFineTrim,
    input logic [7:0]  factoryTest,
    input logic        clockConfigLock,
    input logic        pllLockFlag,
    input logic        oscUpFlag,
    input logic        trimLoaded
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // ****************************************************************
    // Sequences
    // ****************************************************************
    sequence s_wr(logic [9:0] lo, logic [9:0] hi);
        psel && !penable && pwrite && trimLoaded && paddr[11:2] >= lo && paddr[11:2] <= hi;
    endsequence
    sequence s_answer;
        ##1 !pready ##1 pready;
    endsequence

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_ready_answer: assert property (psel && !penable |-> s_answer)
        else $error("pready not two cycles after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_test_refused: assert property (s_wr(`CTRIM_IDX_FTEST3, `CTRIM_IDX_FTEST3) ##0 !specialMode
        |-> ##1 $stable(factoryTest)[*3])
        else $error("test register written outside special mode");
    a_temp_write: assert property (s_wr(`CTRIM_IDX_HTTRIM, `CTRIM_IDX_HTTRIM)
        |-> ##3 tempOffsetEnable == $past(pwdata[7], 3))
        else $error("offset enable not written");
    a_offset_off: assert property (!tempOffsetEnable |-> tempOffsetTrim == 4'h0)
        else $error("offset trim active while disabled");
    a_offset_on: assert property (s_wr(`CTRIM_IDX_HTTRIM, `CTRIM_IDX_HTTRIM) ##0 pwdata[7]
        |-> ##3 tempOffsetTrim == $past(pwdata[3:0], 3))
        else $error("offset trim not applied");
    a_lock_hold: assert property (s_wr(`CTRIM_IDX_OSCTRIM_HI, `CTRIM_IDX_OSCTRIM_LO)
        ##0 clockConfigLock
        |-> ##1 $stable({tempcoTrim, refOscCoarseTrim, refOscFineTrim})[*3])
        else $error("locked oscillator trim changed");
    a_pll_clear: assert property (s_wr(`CTRIM_IDX_OSCTRIM_HI, `CTRIM_IDX_OSCTRIM_LO)
        ##0 (pllClockSelect && !clockConfigLock && !pllLockSet && !oscUpSet)
        ##1 (!pllLockSet && !oscUpSet)
        |-> ##2 !pllLockFlag && !oscUpFlag)
        else $error("status flags not cleared");
    a_tempco_off: assert property (tempcoCompEnable
        == !(tempcoTrim == `CTRIM_TC_OFF_A || tempcoTrim == `CTRIM_TC_OFF_B))
        else $error("tempco enable wrong for code");
    a_unlock_key: assert property (s_wr(`CTRIM_IDX_CLOCK_CONFIG_LOCK, `CTRIM_IDX_CLOCK_CONFIG_LOCK)
        ##0 pwdata[7:0] == `CTRIM_UNLOCK_KEY |-> ##3 !clockConfigLock)
        else $error("key did not unlock");
    a_lock_other: assert property (s_wr(`CTRIM_IDX_CLOCK_CONFIG_LOCK, `CTRIM_IDX_CLOCK_CONFIG_LOCK)
        ##0 pwdata[7:0] != `CTRIM_UNLOCK_KEY |-> ##3 clockConfigLock)
        else $error("other value did not lock");
endmodule // ctrim_bank_chk

// ===== tb_clock_unit_trim_registers.sv
// Self-checking testbench of the trim register bank over APB
`timescale 1ns/10ps
`include "ctrim_regs.vh"

module tb_clock_unit_trim_registers;
    localparam logic [9:0] HT = `CTRIM_IDX_HTTRIM;
    localparam logic [9:0] HI = `CTRIM_IDX_OSCTRIM_HI;
    localparam logic [9:0] LO = `CTRIM_IDX_OSCTRIM_LO;
    localparam logic [9:0] PR = `CTRIM_IDX_CLOCK_CONFIG_LOCK;
    localparam logic [9:0] ST = `CTRIM_IDX_STATUS;
    localparam logic [9:0] FT = `CTRIM_IDX_FTEST3;
    logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        specialMode, pllClockSelect, pllLockSet, oscUpSet, flashValid;
    logic [3:0]  flashTempTrim, tempOffsetTrim, tempcoTrim, refOscCoarseTrim;
    logic [15:0] flashOscTrim;
    logic [5:0]  refOscFineTrim;
    logic [7:0]  factoryTest;
    logic        tempOffsetEnable, tempcoCompEnable, clockConfigLock;
    logic        pllLockFlag, oscUpFlag, trimLoaded;
    int          n_mismatch, samples_checked;

    ctrim_bank u_dut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .specialMode, .pllClockSelect, .pllLockSet, .oscUpSet, .flashValid,
        .flashTempTrim, .flashOscTrim, .tempOffsetEnable, .tempOffsetTrim, .tempcoCompEnable,
        .tempcoTrim, .refOscCoarseTrim, .refOscFineTrim, .factoryTest, .clockConfigLock,
        .pllLockFlag, .oscUpFlag, .trimLoaded);

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic end_of_test();
        if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        @(posedge mclk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge mclk);
            k++;
        end
        if (k >= 20) begin
            n_mismatch++;
            end_of_test();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(rdat, exp);
        chk({31'h0, rerr}, 32'h0);
    endtask

    // ****************************************************************
    // Stimulus
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        #500000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, specialMode, pllClockSelect, pllLockSet, oscUpSet} = 7'h00;
        {flashValid, paddr, pwdata} = 45'h0;
        flashTempTrim = 4'h5;
        flashOscTrim = 16'hA2C7;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        wr(HT, 8'h33);
        rd(HT, 32'h0F);
        flashValid <= 1'b1;
        repeat (3) @(posedge mclk);
        chk({31'h0, trimLoaded}, 32'h1);
        rd(HT, 32'h05);
        rd(HI, 32'hA2);
        rd(LO, 32'hC7);
        wr(HT, 8'hFA);
        rd(HT, 32'h8A);
        chk({27'h0, tempOffsetEnable, tempOffsetTrim}, 32'h1A);
        wr(HT, 8'h7C);
        rd(HT, 32'h0C);
        chk({27'h0, tempOffsetEnable, tempOffsetTrim}, 32'h00);
        wr(PR, 8'h00);
        rd(ST, 32'h0C);
        wr(HI, 8'h55);
        rd(HI, 32'hA2);
        wr(PR, `CTRIM_UNLOCK_KEY);
        chk({31'h0, clockConfigLock}, 32'h0);
        wr(HI, 8'h8F);
        rd(HI, 32'h83);
        wr(LO, 8'h7F);
        chk({18'h0, tempcoTrim, refOscCoarseTrim, refOscFineTrim},
            {18'h0, 4'h8, 4'hD, 6'h3F});
        for (int i = 0; i < 16; i++) begin
            wr(HI, {i[3:0], 4'h0});
            chk({31'h0, tempcoCompEnable}, {31'h0, i != 0 && i != 8});
        end
        wr(LO, 8'h3F);
        chk({18'h0, tempcoTrim, refOscCoarseTrim, refOscFineTrim},
            {18'h0, 4'hF, 4'h0, 6'h3F});
        {pllLockSet, oscUpSet} <= 2'b11;
        @(posedge mclk);
        {pllLockSet, oscUpSet} <= 2'b00;
        repeat (2) @(posedge mclk);
        wr(LO, 8'h01);
        rd(ST, 32'h0B);
        pllClockSelect <= 1'b1;
        wr(LO, 8'h02);
        rd(ST, 32'h08);
        chk({30'h0, pllLockFlag, oscUpFlag}, 32'h0);
        wr(FT, 8'h5A);
        rd(FT, 32'h00);
        specialMode <= 1'b1;
        wr(FT, 8'h5A);
        rd(FT, 32'h5A);
        chk({24'h0, factoryTest}, 32'h5A);
        xfer(1'b0, 10'h2FA, 8'h00);
        chk({31'h0, rerr}, 32'h1);
        end_of_test();
    end
endmodule // tb_clock_unit_trim_registers

bind ctrim_bank ctrim_bank_chk u_chk (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .specialMode, .pllClockSelect, .pllLockSet, .oscUpSet, .tempOffsetEnable,
    .tempOffsetTrim, .tempcoCompEnable, .tempcoTrim, .refOscCoarseTrim, .refOscFineTrim,
    .factoryTest, .clockConfigLock, .pllLockFlag, .oscUpFlag, .trimLoaded);
